// ===== core/effective_address_generator.sv
// Purpose: Effective-address generation with indirect chain following
// Assumes: AXI4-Lite register access, word-read memory port with ack
// Notes: Next instruction may wait while one resolves
// Summary of operation
// RL1 - Extended modes 0..3: second word is the operand, no address work.
// RL2 - Short mode top bit 0: two mode bits above 9-bit field form address.
// RL3 - Extended mode 7, second word top 0: its low 15 bits are the address.
// RL4 - Short mode 7: read word at 9-bit field, use it as address.
// RL5 - Extended mode 7, second word top 1: read at its low 15 bits.
// RL6 - Fetched word marked indirect triggers another memory read.
// RL7 - Chains stop at five levels for one word, four for two words.
// RL8 - Short mode 5: field plus first index register.
// RL9 - Extended mode 5: first index register, bit 7 picks pre or post.
// RL10 - Bit 7 clear: add index to second word before indirect steps.
// RL11 - Bit 7 set: follow indirect steps first, then add index.
// RL12 - Short mode 6: field plus second index register.
// RL13 - Extended mode 6: second index register, same pre/post choice.
// RL14 - Short mode 4: field plus program counter.
// RL15 - Program counter used is instruction address plus one.
// RL16 - Extended mode 4: second word plus program counter.
// RL17 - Next instruction is taken in while the current one resolves.
// RL18 - Top bit of an address word flags indirection.
// RL19 - Extended mode comes from bits 0 to 2 of the first word.
// RL20 - Extended when opcode field is 00 and mode field is 6.
// RL21 - Index and relative sums are cut to 15 bits.
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator #(
    parameter int AXI_ADDR_W = 8
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic MEM_RD_O,
    output logic [14:0] MEM_ADDR_O,
    input wire logic MEM_ACK_I,
    input wire logic [15:0] MEM_DATA_I,
    output logic EA_VALID_O,
    output logic [15:0] EA_RESULT_O,
    output logic EA_IMM_O,
    output logic EA_DEEP_O
);
    if (AXI_ADDR_W < 6 || AXI_ADDR_W > 32) begin : g_bad
        $error("AXI_ADDR_W must lie in 6..32");
    end

    typedef enum logic {ST_IDLE, ST_FETCH} state_type;

    // Address and data may arrive in either order
    logic aw_full_reg;
    logic [7:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // Software-visible registers
    eag_pkg::instr_type stage_reg;
    logic done_reg;
    logic deep_reg;
    logic drop_reg;

    // Engine state
    state_type state_reg;
    state_type state_next;
    logic [14:0] mem_addr_reg;
    logic [14:0] mem_addr_next;
    logic [2:0] levels_reg;
    logic [2:0] levels_next;
    logic [2:0] limit_reg;
    logic [2:0] limit_next;
    logic post_reg;
    logic post_next;
    logic [14:0] offset_reg;
    logic [14:0] offset_next;
    logic [15:0] result_reg;
    logic [15:0] result_next;
    logic imm_reg;
    logic imm_next;
    logic fault_reg;
    logic fault_next;
    logic valid_reg;
    logic valid_next;

    // Upper address bits must be zero for a read hit; writes only see bits 7:0
    function automatic logic hit(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] ofs);
        logic [31:0] wide;
        wide = 32'h0000_0000;
        wide[AXI_ADDR_W-1:0] = a;
        return (wide[31:2] == {24'h000000, ofs[7:2]});
    endfunction

    wire aw_take = S_AXI_AWVALID_I & ~aw_full_reg;
    wire w_take = S_AXI_WVALID_I & ~w_full_reg;
    wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire ar_take = S_AXI_ARVALID_I & ~rvalid_reg;
    wire [AXI_ADDR_W-1:0] awa = AXI_ADDR_W'(aw_addr_reg);

    wire wr_ctrl = do_write & hit(awa, eag_pkg::OFS_CTRL);
    wire wr_word0 = do_write & hit(awa, eag_pkg::OFS_WORD0);
    wire wr_word1 = do_write & hit(awa, eag_pkg::OFS_WORD1);
    wire wr_xreg = do_write & hit(awa, eag_pkg::OFS_XREG);
    wire wr_breg = do_write & hit(awa, eag_pkg::OFS_BREG);
    wire wr_preg = do_write & hit(awa, eag_pkg::OFS_PREG);
    wire wr_status = do_write & hit(awa, eag_pkg::OFS_STATUS);
    wire wr_ro = do_write & (hit(awa, eag_pkg::OFS_RESULT)
                             | hit(awa, eag_pkg::OFS_LEVELS));
    wire wr_hit = wr_ctrl | wr_word0 | wr_word1 | wr_xreg | wr_breg | wr_preg | wr_status | wr_ro;

    wire start_req = wr_ctrl & w_strb_reg[0] & w_data_reg[eag_pkg::CTRL_START_BIT];
    wire clr_done = wr_status & w_strb_reg[0] & w_data_reg[eag_pkg::ST_DONE_BIT];
    wire clr_deep = wr_status & w_strb_reg[0] & w_data_reg[eag_pkg::ST_DEEP_BIT];
    wire clr_drop = wr_status & w_strb_reg[0] & w_data_reg[eag_pkg::ST_DROP_BIT];

    // Next instruction may wait here mid-chain
    logic slot_ready;
    logic slot_valid;
    eag_pkg::instr_type slot_data;
    eag_pkg::decode_type dec;
    wire pop = slot_valid & (state_reg == ST_IDLE);

    instr_slot #(
        .WIDTH($bits(eag_pkg::instr_type))
    ) u_slot (
        .clk_i(REF_CLK_I),
        .rst_n_i(NRST_I),
        .in_valid_i(start_req),
        .in_ready_o(slot_ready),
        .in_data_i(stage_reg),
        .out_valid_o(slot_valid),
        .out_ready_i(pop),
        .out_data_o(slot_data)
    ); // RL17

    mode_decoder u_dec (
        .instr_i(slot_data),
        .dec_o(dec)
    );

    wire busy = (state_reg != ST_IDLE) | slot_valid;
    wire [15:0] status_word = {10'h000, drop_reg, slot_valid, imm_reg, deep_reg, done_reg, busy};

    // Read mux
    wire [AXI_ADDR_W-1:0] ar = S_AXI_ARADDR_I;
    wire rd_ctrl = hit(ar, eag_pkg::OFS_CTRL);
    wire rd_word0 = hit(ar, eag_pkg::OFS_WORD0);
    wire rd_word1 = hit(ar, eag_pkg::OFS_WORD1);
    wire rd_xreg = hit(ar, eag_pkg::OFS_XREG);
    wire rd_breg = hit(ar, eag_pkg::OFS_BREG);
    wire rd_preg = hit(ar, eag_pkg::OFS_PREG);
    wire rd_status = hit(ar, eag_pkg::OFS_STATUS);
    wire rd_result = hit(ar, eag_pkg::OFS_RESULT);
    wire rd_levels = hit(ar, eag_pkg::OFS_LEVELS);
    wire rd_hit = rd_ctrl | rd_word0 | rd_word1 | rd_xreg | rd_breg | rd_preg | rd_status
                  | rd_result | rd_levels;
    wire [15:0] rd_word = rd_word0 ? stage_reg.w0 :
                          rd_word1 ? stage_reg.w1 :
                          rd_xreg ? stage_reg.xr :
                          rd_breg ? stage_reg.br :
                          rd_preg ? stage_reg.pr :
                          rd_status ? status_word :
                          rd_result ? result_reg :
                          rd_levels ? {13'h0000, levels_reg} : 16'h0000;

    // Chain step evaluation
    wire fetch_ack = (state_reg == ST_FETCH) & MEM_ACK_I;
    wire [2:0] levels_inc = levels_reg + 3'h1;
    wire deeper = MEM_DATA_I[eag_pkg::IND_BIT]; // RL18
    wire over = deeper & (levels_inc >= limit_reg); // RL7
    wire [14:0] chain_addr = MEM_DATA_I[14:0];
    wire [14:0] final_addr = post_reg ? eag_pkg::add15(chain_addr, offset_reg) : chain_addr; // RL11 RL21

    always_comb begin
        state_next = state_reg;
        mem_addr_next = mem_addr_reg;
        levels_next = levels_reg;
        limit_next = limit_reg;
        post_next = post_reg;
        offset_next = offset_reg;
        result_next = result_reg;
        imm_next = imm_reg;
        fault_next = fault_reg;
        valid_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (pop) begin
                    levels_next = 3'h0;
                    limit_next = dec.limit;
                    post_next = dec.post;
                    offset_next = dec.offset;
                    imm_next = dec.imm;
                    fault_next = 1'b0;
                    if (dec.chase) begin
                        mem_addr_next = dec.addr; // RL4 RL5
                        state_next = ST_FETCH;
                    end else begin
                        result_next = dec.imm ? dec.operand : {1'b0, dec.addr}; // RL1
                        valid_next = 1'b1;
                    end
                end
            end
            ST_FETCH: begin
                if (fetch_ack) begin
                    levels_next = levels_inc;
                    if (deeper && !over) begin
                        mem_addr_next = chain_addr; // RL6
                    end else if (over) begin
                        // Runaway chain ends in a fault
                        fault_next = 1'b1; // RL7
                        result_next = 16'h0000;
                        valid_next = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        result_next = {1'b0, final_addr};
                        valid_next = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_reg <= ST_IDLE;
            mem_addr_reg <= 15'h0000;
            levels_reg <= 3'h0;
            limit_reg <= 3'h0;
            post_reg <= 1'b0;
            offset_reg <= 15'h0000;
            result_reg <= eag_pkg::RST_WORD;
            imm_reg <= 1'b0;
            fault_reg <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mem_addr_reg <= mem_addr_next;
            levels_reg <= levels_next;
            limit_reg <= limit_next;
            post_reg <= post_next;
            offset_reg <= offset_next;
            result_reg <= result_next;
            imm_reg <= imm_next;
            fault_reg <= fault_next;
            valid_reg <= valid_next;
        end
    end

    // Set wins over a clear in one cycle
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            done_reg <= 1'b0;
            deep_reg <= 1'b0;
            drop_reg <= 1'b0;
        end else begin
            done_reg <= valid_next | (done_reg & ~clr_done);
            deep_reg <= (valid_next & fault_next) | (deep_reg & ~clr_deep);
            drop_reg <= (start_req & ~slot_ready) | (drop_reg & ~clr_drop);
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            stage_reg <= '0;
        end else begin
            if (wr_word0) stage_reg.w0 <= eag_pkg::merge16(stage_reg.w0, w_data_reg, w_strb_reg);
            if (wr_word1) stage_reg.w1 <= eag_pkg::merge16(stage_reg.w1, w_data_reg, w_strb_reg);
            if (wr_xreg) stage_reg.xr <= eag_pkg::merge16(stage_reg.xr, w_data_reg, w_strb_reg);
            if (wr_breg) stage_reg.br <= eag_pkg::merge16(stage_reg.br, w_data_reg, w_strb_reg);
            if (wr_preg) stage_reg.pr <= eag_pkg::merge16(stage_reg.pr, w_data_reg, w_strb_reg);
        end
    end

    // Write channels
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= eag_pkg::RESP_OKAY;
        end else begin
            aw_full_reg <= aw_take | (aw_full_reg & ~do_write);
            w_full_reg <= w_take | (w_full_reg & ~do_write);
            if (aw_take) aw_addr_reg <= 8'(S_AXI_AWADDR_I);
            if (w_take) w_data_reg <= S_AXI_WDATA_I;
            if (w_take) w_strb_reg <= S_AXI_WSTRB_I;
            bvalid_reg <= do_write | (bvalid_reg & ~S_AXI_BREADY_I);
            if (do_write) bresp_reg <= wr_hit ? eag_pkg::RESP_OKAY : eag_pkg::RESP_SLVERR;
        end
    end

    // Read channel
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= eag_pkg::RESP_OKAY;
            rdata_reg <= 32'h0;
        end else begin
            rvalid_reg <= ar_take | (rvalid_reg & ~S_AXI_RREADY_I);
            if (ar_take) rdata_reg <= {16'h0000, rd_word};
            if (ar_take) rresp_reg <= rd_hit ? eag_pkg::RESP_OKAY : eag_pkg::RESP_SLVERR;
        end
    end

    assign S_AXI_AWREADY_O = ~aw_full_reg;
    assign S_AXI_WREADY_O = ~w_full_reg;
    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_BRESP_O = bresp_reg;
    assign S_AXI_ARREADY_O = ~rvalid_reg;
    assign S_AXI_RVALID_O = rvalid_reg;
    assign S_AXI_RDATA_O = rdata_reg;
    assign S_AXI_RRESP_O = rresp_reg;
    assign MEM_RD_O = (state_reg == ST_FETCH);
    assign MEM_ADDR_O = mem_addr_reg;
    assign EA_VALID_O = valid_reg;
    assign EA_RESULT_O = result_reg;
    assign EA_IMM_O = imm_reg;
    assign EA_DEEP_O = fault_reg;
endmodule
`default_nettype wire

// ===== core/eag_pkg.sv
// Purpose: Shared constants, carriers and helpers of the address unit
// Assumes: 16-bit words, 15-bit word addresses
// Notes: Register map sits on a 32-bit AXI4-Lite slave
package eag_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 15;
    localparam int OPC_LSB = 12;
    localparam int MODE_LSB = 9;
    localparam int POST_BIT = 7;
    localparam int IND_BIT = 15;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WORD0 = 8'h04;
    localparam logic [7:0] OFS_WORD1 = 8'h08;
    localparam logic [7:0] OFS_XREG = 8'h0c;
    localparam logic [7:0] OFS_BREG = 8'h10;
    localparam logic [7:0] OFS_PREG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_RESULT = 8'h1c;
    localparam logic [7:0] OFS_LEVELS = 8'h20;
    localparam int CTRL_START_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_DEEP_BIT = 2;
    localparam int ST_IMM_BIT = 3;
    localparam int ST_PEND_BIT = 4;
    localparam int ST_DROP_BIT = 5;
    localparam logic [3:0] EXT_OPCODE = 4'h0;
    localparam logic [2:0] EXT_MFIELD = 3'h6;
    localparam logic [2:0] MODE_REL = 3'h4;
    localparam logic [2:0] MODE_XIDX = 3'h5;
    localparam logic [2:0] MODE_BIDX = 3'h6;
    localparam logic [2:0] MODE_IND = 3'h7;
    localparam logic [2:0] LIMIT_SINGLE = 3'h5;
    localparam logic [2:0] LIMIT_EXT = 3'h4;
    localparam logic [14:0] P_STEP = 15'h0001;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] xr;
        logic [15:0] br;
        logic [15:0] pr;
    } instr_type;

    typedef struct packed {
        logic imm;
        logic chase;
        logic post;
        logic [14:0] addr;
        logic [14:0] offset;
        logic [2:0] limit;
        logic [15:0] operand;
    } decode_type;

    function automatic logic [14:0] add15(input logic [14:0] a, input logic [14:0] b);
        logic [15:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[14:0];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) r[7:0] = d[7:0];
        if (strb[1]) r[15:8] = d[15:8];
        return r;
    endfunction
endpackage

// ===== core/instr_slot.sv
// Purpose: One-entry holding slot for the next instruction
// Assumes: Source and sink share one clock
// Notes: Filling is refused while the slot holds an entry
`timescale 1ns/1ps
`default_nettype none
module instr_slot #(
    parameter int WIDTH = 80
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    if (WIDTH < 1) begin : g_bad
        $error("instr_slot WIDTH must be positive");
    end

    logic full_reg;
    logic [WIDTH-1:0] data_reg;
    wire push = in_valid_i & ~full_reg;
    wire pop = full_reg & out_ready_i;

    assign in_ready_o = ~full_reg;
    assign out_valid_o = full_reg;
    assign out_data_o = data_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            full_reg <= 1'b0;
            data_reg <= '0;
        end else begin
            full_reg <= push | (full_reg & ~pop);
            if (push) data_reg <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// ===== core/mode_decoder.sv
// Purpose: Decode addressing mode of a one- or two-word instruction
// Assumes: Purely combinational, fields per eag_pkg positions
// Notes: Post-indexing with no indirect step collapses to a plain sum
`timescale 1ns/1ps
`default_nettype none
module mode_decoder (
    input wire eag_pkg::instr_type instr_i,
    output eag_pkg::decode_type dec_o
);
    wire [15:0] w0 = instr_i.w0;
    wire [15:0] w1 = instr_i.w1;
    wire [2:0] m_field = w0[eag_pkg::MODE_LSB +: 3];
    wire is_ext = (w0[eag_pkg::OPC_LSB +: 4] == eag_pkg::EXT_OPCODE)
                  & (m_field == eag_pkg::EXT_MFIELD); // RL20
    wire [2:0] x_field = w0[2:0]; // RL19
    wire [14:0] short_a = {6'h00, w0[8:0]};
    wire [14:0] ext_a = w1[14:0];
    wire ext_ind = w1[eag_pkg::IND_BIT]; // RL18
    wire post_sel = w0[eag_pkg::POST_BIT];
    wire [14:0] p_next = eag_pkg::add15(instr_i.pr[14:0], eag_pkg::P_STEP); // RL15
    wire [14:0] ext_idx = (x_field == eag_pkg::MODE_XIDX) ? instr_i.xr[14:0] : instr_i.br[14:0];

    always_comb begin
        dec_o = '0;
        dec_o.operand = w1;
        if (!is_ext) begin
            dec_o.limit = eag_pkg::LIMIT_SINGLE;
            unique case (m_field)
                eag_pkg::MODE_REL: dec_o.addr = eag_pkg::add15(p_next, short_a); // RL14
                eag_pkg::MODE_XIDX: dec_o.addr = eag_pkg::add15(instr_i.xr[14:0], short_a); // RL8
                eag_pkg::MODE_BIDX: dec_o.addr = eag_pkg::add15(instr_i.br[14:0], short_a); // RL12
                eag_pkg::MODE_IND: begin
                    dec_o.addr = short_a; // RL4
                    dec_o.chase = 1'b1;
                end
                default: dec_o.addr = {4'h0, m_field[1:0], w0[8:0]}; // RL2
            endcase
        end else begin
            dec_o.limit = eag_pkg::LIMIT_EXT;
            unique case (x_field)
                eag_pkg::MODE_REL: begin
                    dec_o.addr = eag_pkg::add15(p_next, ext_a); // RL16
                    dec_o.chase = ext_ind;
                end
                eag_pkg::MODE_XIDX, eag_pkg::MODE_BIDX: begin // RL9 RL13
                    dec_o.chase = ext_ind;
                    if (post_sel && ext_ind) begin
                        dec_o.addr = ext_a; // RL11
                        dec_o.post = 1'b1;
                        dec_o.offset = ext_idx;
                    end else begin
                        dec_o.addr = eag_pkg::add15(ext_a, ext_idx); // RL10 RL21
                    end
                end
                eag_pkg::MODE_IND: begin
                    dec_o.addr = ext_a; // RL3 RL5
                    dec_o.chase = ext_ind;
                end
                default: dec_o.imm = 1'b1; // RL1
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verif/eag_checker.sv
// Purpose: Assertions on chain reads and results
// Assumes: Bound to the top module
// Notes: Depth counts acks since the last result
`timescale 1ns/1ps
`default_nettype none
module eag_checker (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic MEM_RD_O,
    input wire logic [14:0] MEM_ADDR_O,
    input wire logic MEM_ACK_I,
    input wire logic [15:0] MEM_DATA_I,
    input wire logic EA_VALID_O,
    input wire logic [15:0] EA_RESULT_O,
    input wire logic EA_DEEP_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    logic [3:0] acks_reg;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
        if (!NRST_I) acks_reg <= 4'h0;
        else acks_reg <= EA_VALID_O ? 4'h0 : acks_reg + {3'h0, MEM_RD_O & MEM_ACK_I};
    sequence last_word_s; MEM_RD_O && MEM_ACK_I && !MEM_DATA_I[15]; endsequence
    sequence next_word_s; MEM_RD_O && MEM_ACK_I && MEM_DATA_I[15]; endsequence
    chain_end_a: assert property (last_word_s |=> EA_VALID_O && !MEM_RD_O) else $error("chain end");
    chain_step_a: assert property (next_word_s |=>
        (MEM_RD_O && MEM_ADDR_O == $past(MEM_DATA_I[14:0])) || (EA_VALID_O && EA_DEEP_O))
        else $error("chain step");
    fault_depth_a: assert property (EA_VALID_O && EA_DEEP_O |->
        acks_reg inside {4'h4, 4'h5} && EA_RESULT_O == 16'h0000) else $error("fault depth");
    depth_cap_a: assert property (acks_reg <= 4'h5) else $error("too many reads");
    addr_hold_a: assert property (MEM_RD_O && !MEM_ACK_I |=> MEM_RD_O && $stable(MEM_ADDR_O)) else $error("read moved");
    result_idle_a: assert property (EA_VALID_O |-> !MEM_RD_O) else $error("result with read open");
    result_hold_a: assert property ($changed(EA_RESULT_O) |-> EA_VALID_O) else $error("result moved");
    resp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O) else $error("bvalid dropped");
endmodule
`default_nettype wire

// ===== verif/eag_mem_model.sv
// Purpose: Word memory answering indirect reads
// Assumes: Read held until ack, one ack per read
// Notes: Data inverts when idle so stale words fail
`timescale 1ns/1ps
`default_nettype none
module eag_mem_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rd_i,
    input wire logic [14:0] addr_i,
    input wire logic [3:0] dly_i,
    output logic ack_o,
    output logic [15:0] data_o
);
    logic [15:0] mem [0:32767];
    logic [3:0] wait_reg;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            data_o <= 16'h5a5a;
            wait_reg <= 4'h0;
        end else if (rd_i && !ack_o && wait_reg >= dly_i) begin
            ack_o <= 1'b1;
            data_o <= mem[addr_i];
            wait_reg <= 4'h0;
        end else begin
            ack_o <= 1'b0;
            data_o <= ~data_o;
            wait_reg <= (rd_i && !ack_o) ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ===== verif/test_effective_address_generator.sv
// Purpose: Self-checking bench of the address unit
// Assumes: Memory answers after a random delay
// Notes: Starts go in pairs so the second waits in the slot
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module test_effective_address_generator;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] dly = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, mrd, mack, ev, eimm, edeep;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [14:0] maddr;
    logic [15:0] mdata, eres;
    int err_total = 0, checked = 0, cyc = 0, got = 0, sent = 0, e, lv_last;
    int exp_q[$];
    initial forever #5 clk = ~clk;
    effective_address_generator u_effective_address_generator (.REF_CLK_I(clk), .NRST_I(nrst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .MEM_RD_O(mrd), .MEM_ADDR_O(maddr), .MEM_ACK_I(mack), .MEM_DATA_I(mdata),
        .EA_VALID_O(ev), .EA_RESULT_O(eres), .EA_IMM_O(eimm), .EA_DEEP_O(edeep));
    eag_mem_model u_mem (.clk_i(clk), .rst_n_i(nrst), .rd_i(mrd), .addr_i(maddr), .dly_i(dly),
        .ack_o(mack), .data_o(mdata));
    task automatic summarize();
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Bits 15:0 value, 16 immediate, 17 chain fault
    function automatic int ref_ea(input int w0, w1, x, b, p, output int lv);
        int a, idx, lim = 5, ind, post = 0, d, m;
        lv = 0;
        m = w0[11:9];
        a = w0[8:0];
        ind = m == 7;
        if (w0[15:9] == 7'h06) begin
            m = w0[2:0];
            if (m < 4) return 32'h10000 | w1[15:0];
            lim = 4;
            a = w1[14:0];
            ind = w1[15];
            post = w0[7] && m != 4 && ind;
        end else if (m < 4) a = a | m << 9;
        idx = (m == 4 ? p + 1 : m == 5 ? x : m == 6 ? b : 0) & 32'h7fff;
        if (!post) a = (a + idx) & 32'h7fff;
        while (ind) begin
            d = u_mem.mem[a];
            lv++;
            if (d[15] && lv == lim) return 32'h20000;
            a = d & 32'h7fff;
            ind = d[15];
        end
        if (post) a = (a + idx) & 32'h7fff;
        return a;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = eag_pkg::RESP_OKAY);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic start(input int w0, w1, x, b, p);
        exp_q.push_back(ref_ea(w0, w1, x, b, p, lv_last));
        sent++;
        wr(eag_pkg::OFS_WORD0, w0);
        wr(eag_pkg::OFS_WORD1, w1);
        wr(eag_pkg::OFS_XREG, x);
        wr(eag_pkg::OFS_BREG, b);
        wr(eag_pkg::OFS_PREG, p);
        wr(eag_pkg::OFS_CTRL, 32'h1);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            summarize();
        end
        if (nrst && ev) begin
            e = exp_q.pop_front();
            got++;
            `CHK("result", e[15:0], eres)
            `CHK("imm", e[16], eimm)
            `CHK("deep", e[17], edeep)
        end
    end
    initial begin
        int w0;
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(32'h41c325a5));
        for (int i = 0; i < 32768; i++) u_mem.mem[i] = 16'($urandom);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // All modes, random memory delay
        for (int i = 0; i < 256; i++) begin
            w0 = i[3] ? {7'h06, 6'($urandom), i[2:0]} : {4'($urandom_range(15, 1)), i[2:0], 9'($urandom)};
            dly <= 4'($urandom_range(12));
            start(w0, 16'($urandom), $urandom, $urandom, $urandom);
            if (i[0]) begin
                while (got < sent) @(posedge clk);
                rd(eag_pkg::OFS_LEVELS, d, r);
                `CHK("levels", 32'(lv_last), d)
            end
        end
        wr(8'h24, 32'h1, eag_pkg::RESP_SLVERR);
        rd(8'h24, d, r);
        `CHK("rresp", eag_pkg::RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        summarize();
    end
endmodule
bind effective_address_generator eag_checker u_eag_checker (.REF_CLK_I, .NRST_I, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
    .MEM_RD_O, .MEM_ADDR_O, .MEM_ACK_I, .MEM_DATA_I, .EA_VALID_O, .EA_RESULT_O, .EA_DEEP_O);
`default_nettype wire
